// >>> src/spc_checker.sv
// Functional notes
// - Non-secure master never matches a Secure stream mapping group.
// - Non-secure group never routes to a Secure context bank.
// - In version-1 mode Non-secure bank never signals through a Secure context interrupt.
// - Non-secure bank never starts its walk in Secure level 1 tables.
// - Non-secure level 1 walk never continues into Secure level 2.
// - Non-secure level 2 walk never continues into Secure level 3.
// - Non-secure level 3 walk never targets Secure memory.
// - Secure master never matches a Non-secure stream mapping group.
// - Secure group never routes to a Non-secure context bank.
// - Secure context banks never perform nested stage 1 plus stage 2.
// - In version-1 mode Secure bank never uses Non-secure context interrupt.
// - Secure-programmed group count splits groups; groups at or above it are Secure.
// - Secure-programmed bank count sets Non-secure visible banks; rest Secure.
// - In version-1 mode Secure-programmed count splits context interrupts.
// - Secure accesses read and write Non-secure bank registers, not using them.
// - Secure contexts may walk Non-secure tables that map Non-secure memory.
// - Any other cross-state association is permitted, bypass routes included.
// - Page size is 4KB or 64KB, reported in the identification register.
// - Each register page is one page-size aligned region.
// - Pages per half equal two to the power of index plus one.
// - Global space at frame base; base aligned; both halves equal size.
// - Context bank n page sits n pages above the global space top.
// - Secure master translated only by stage 1 with stage 2 bypass context.
module spc_checker
    import spc_pkg::*;
#(
    parameter int              NUM_GROUPS       = 16,
    parameter int              NUM_BANKS        = 8,
    parameter int              NUM_IRQS         = 8,
    parameter bit              PAGE_64K         = 1'b0,
    parameter logic [2:0]      PAGE_COUNT_INDEX = 3'h3,
    parameter logic [31:0]     FRAME_BASE       = 32'h0000_0000
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire spc_pkg::spc_apb_req_type apb_req,
    output logic [spc_pkg::DATA_W-1:0]    prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire spc_pkg::spc_txn_type     txn,
    output spc_pkg::spc_verdict_type      verdict
);
    import spc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    localparam int PAGE_SHIFT = PAGE_64K ? PAGE_SHIFT_64K : PAGE_SHIFT_4K;
    localparam int HALF_PAGES = 1 << (int'(PAGE_COUNT_INDEX) + 1);

    typedef struct packed {
        logic [IDX_W-1:0]                ns_groups;
        logic [IDX_W-1:0]                ns_banks;
        logic [IDX_W-1:0]                ns_irqs;
        logic                            v1_mode;
        logic [NUM_BANKS-1:0][DATA_W-1:0] ctc;
        logic [DATA_W-1:0]               prdata;
        logic                            pready;
        logic                            pslverr;
        spc_verdict_type                 verdict;
        logic [IDX_W-1:0]                fault_count;
        spc_fault_type                   last_fault;
    } spc_state_type;

    spc_state_type state_reg;
    spc_state_type state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Index at or above the Non-secure count belongs to the Secure state
    function automatic logic is_secure_idx(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] ns_count);
        is_secure_idx = (idx >= ns_count);
    endfunction

    // Open set: only the listed illegal cases fault; anything not matched, including bypass routes, is permitted
    function automatic spc_fault_type check_txn(input spc_txn_type t, input spc_state_type s);
        logic          grp_sec;
        logic          bank_sec;
        logic          irq_sec;
        spc_stage_type stage;
        grp_sec  = is_secure_idx(t.group, s.ns_groups);
        bank_sec = is_secure_idx(t.bank, s.ns_banks);
        irq_sec  = is_secure_idx(t.irq, s.ns_irqs);
        stage    = spc_stage_type'(s.ctc[t.bank[$clog2(NUM_BANKS)-1:0]][1:0]);
        check_txn = FLT_NONE;
        if (32'(t.group) >= NUM_GROUPS || t.route == ROUTE_FAULT ||
            (t.route == ROUTE_CONTEXT && (32'(t.bank) >= NUM_BANKS || 32'(t.irq) >= NUM_IRQS))) begin
            check_txn = FLT_RANGE;
        end else if (!t.secure && grp_sec) begin
            check_txn = FLT_NS_TO_S_GROUP;
        end else if (t.secure && !grp_sec) begin
            check_txn = FLT_S_TO_NS_GROUP;
        end else if (t.route == ROUTE_CONTEXT) begin
            if (!grp_sec && bank_sec) begin
                check_txn = FLT_NSGRP_SBANK;
            end else if (grp_sec && !bank_sec) begin
                check_txn = FLT_SGRP_NSBANK;
            end else if (bank_sec && stage == STAGE_NESTED) begin
                check_txn = FLT_S_NESTED;
            end else if (t.secure && stage != STAGE_S1_S2_BYPASS) begin
                check_txn = FLT_S_NOT_S1;
            end else if (!bank_sec && irq_sec && s.v1_mode) begin
                check_txn = FLT_NSBANK_SIRQ;
            end else if (bank_sec && !irq_sec && s.v1_mode) begin
                check_txn = FLT_SBANK_NSIRQ;
            end else if (!bank_sec && t.walk_secure[0]) begin
                check_txn = FLT_NSBANK_SWALK;
            end else if (!t.walk_secure[0] && t.walk_secure[1]) begin
                check_txn = FLT_WALK_L2;
            end else if (!t.walk_secure[1] && t.walk_secure[2]) begin
                check_txn = FLT_WALK_L3;
            end else if (!t.walk_secure[2] && t.target_secure) begin
                check_txn = FLT_TARGET;
            end
            // Secure bank with all-Non-secure walk and target falls through as legal
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Frame decode
    logic [ADDR_W-1:0] frame_off;
    logic [ADDR_W-1:0] page_num;
    logic [11:0]       reg_off;
    logic              in_frame;
    logic              in_global;
    logic [ADDR_W-1:0] bank_num;
    logic              bank_hit;
    logic              sec_access;
    logic [NUM_BANKS-1:0] bank_sec_vec;

    always_comb begin
        frame_off  = apb_req.paddr - FRAME_BASE;
        page_num   = frame_off >> PAGE_SHIFT;
        reg_off    = frame_off[11:0];
        in_frame   = (page_num < 32'(2 * HALF_PAGES));
        in_global  = (page_num < 32'(HALF_PAGES));
        bank_num   = page_num - 32'(HALF_PAGES);
        bank_hit   = in_frame && !in_global && (bank_num < 32'(NUM_BANKS)) && (reg_off == OFF_CTC);
        sec_access = !apb_req.pprot[1];
        for (int i = 0; i < NUM_BANKS; i++) begin
            bank_sec_vec[i] = is_secure_idx(IDX_W'(i), state_reg.ns_banks);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic                    acc_setup;
    logic                    acc_commit;
    logic [$clog2(NUM_BANKS)-1:0] bank_sel;
    logic [IDX_W-1:0]        vis_groups;
    logic [IDX_W-1:0]        vis_banks;
    spc_fault_type           txn_fault;

    always_comb begin
        state_next = state_reg;
        acc_setup  = apb_req.psel && apb_req.penable && !state_reg.pready;
        acc_commit = apb_req.psel && apb_req.penable && state_reg.pready;
        bank_sel   = bank_num[$clog2(NUM_BANKS)-1:0];
        // Non-secure view only counts what was left to it
        vis_groups = sec_access ? IDX_W'(NUM_GROUPS) : state_reg.ns_groups;
        vis_banks  = sec_access ? IDX_W'(NUM_BANKS) : state_reg.ns_banks;
        txn_fault  = check_txn(txn, state_reg);

        // Answer lags the access phase by one cycle so data is prepared ahead of commit
        state_next.pready  = acc_setup;
        state_next.pslverr = 1'b0;
        state_next.prdata  = '0;
        if (acc_setup) begin
            if (in_global && page_num == '0) begin
                unique case (reg_off)
                    OFF_SCR0: begin
                        state_next.pslverr = !sec_access;
                        if (sec_access) begin
                            state_next.prdata[SCR0_GROUPS_LSB +: IDX_W] = state_reg.ns_groups;
                            state_next.prdata[SCR0_BANKS_LSB +: IDX_W]  = state_reg.ns_banks;
                        end
                    end
                    OFF_SCR1: begin
                        state_next.pslverr = !sec_access;
                        if (sec_access) begin
                            state_next.prdata[SCR1_IRQS_LSB +: IDX_W] = state_reg.ns_irqs;
                            state_next.prdata[SCR1_V1_BIT]            = state_reg.v1_mode;
                        end
                    end
                    OFF_IDR1: begin
                        state_next.prdata[IDR1_GROUPS_LSB +: IDX_W] = vis_groups;
                        state_next.prdata[IDR1_BANKS_LSB +: IDX_W]  = vis_banks;
                        state_next.prdata[IDR1_PCI_LSB +: 3]        = PAGE_COUNT_INDEX;
                        state_next.prdata[IDR1_PAGE64_BIT]          = PAGE_64K;
                    end
                    OFF_STAT: begin
                        state_next.prdata[STAT_COUNT_LSB +: IDX_W] = state_reg.fault_count;
                        state_next.prdata[STAT_CODE_LSB +: 4]      = state_reg.last_fault;
                    end
                    default: state_next.prdata = '0;
                endcase
            end else if (bank_hit) begin
                // Secure banks read as zero to Non-secure accesses; Secure sees every copy
                if (sec_access || !bank_sec_vec[bank_sel]) begin
                    state_next.prdata = state_reg.ctc[bank_sel];
                end
            end
            // Unimplemented pages and space above the frame read as zero
        end

        if (acc_commit && apb_req.pwrite && !state_reg.pslverr) begin
            if (in_global && page_num == '0 && sec_access) begin
                if (reg_off == OFF_SCR0) begin
                    state_next.ns_groups = apb_req.pwdata[SCR0_GROUPS_LSB +: IDX_W];
                    state_next.ns_banks  = apb_req.pwdata[SCR0_BANKS_LSB +: IDX_W];
                end
                if (reg_off == OFF_SCR1) begin
                    state_next.ns_irqs = apb_req.pwdata[SCR1_IRQS_LSB +: IDX_W];
                    state_next.v1_mode = apb_req.pwdata[SCR1_V1_BIT];
                end
            end else if (bank_hit && (sec_access || !bank_sec_vec[bank_sel])) begin
                state_next.ctc[bank_sel] = apb_req.pwdata;
            end
        end

        // Verdict one cycle after the request; a fault carries only its code
        state_next.verdict.valid  = txn.valid;
        state_next.verdict.permit = txn.valid && (txn_fault == FLT_NONE);
        state_next.verdict.code   = txn.valid ? txn_fault : FLT_NONE;
        if (txn.valid && txn_fault != FLT_NONE) begin
            state_next.last_fault = txn_fault;
            if (state_reg.fault_count != '1) begin
                state_next.fault_count = state_reg.fault_count + IDX_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg             <= '0;
            state_reg.ns_groups   <= NS_COUNT_RST;
            state_reg.ns_banks    <= NS_COUNT_RST;
            state_reg.ns_irqs     <= NS_COUNT_RST;
            state_reg.v1_mode     <= V1_MODE_RST;
            state_reg.ctc         <= {NUM_BANKS{CTC_RST}};
            state_reg.last_fault  <= FLT_NONE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata  = state_reg.prdata;
    assign pready  = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign verdict = state_reg.verdict;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic grp_sec_c;
    logic bank_sec_c;
    logic irq_sec_c;
    logic in_ctx;
    logic ns_acc_c;
    logic gp0_hit_c;
    spc_stage_type stage_c;

    always_comb begin
        grp_sec_c  = is_secure_idx(txn.group, state_reg.ns_groups);
        bank_sec_c = is_secure_idx(txn.bank, state_reg.ns_banks);
        irq_sec_c  = is_secure_idx(txn.irq, state_reg.ns_irqs);
        in_ctx     = txn.valid && txn.route == ROUTE_CONTEXT && 32'(txn.bank) < NUM_BANKS
                     && 32'(txn.group) < NUM_GROUPS && 32'(txn.irq) < NUM_IRQS;
        stage_c    = spc_stage_type'(state_reg.ctc[txn.bank[$clog2(NUM_BANKS)-1:0]][1:0]);
        ns_acc_c   = apb_req.pprot[1];
        gp0_hit_c  = in_global && page_num == '0;
    end

    sequence seq_refused;
        verdict.valid && !verdict.permit;
    endsequence

    sequence seq_apb_access;
        apb_req.psel && apb_req.penable && !pready ##1 apb_req.psel && apb_req.penable && pready;
    endsequence

    AST_NS_MASTER_S_GROUP: assert property (@(posedge clk) disable iff (!rst_b)
        txn.valid && !txn.secure && grp_sec_c |=> seq_refused)
        else $error("Non-secure master reached a Secure group");
    AST_S_MASTER_NS_GROUP: assert property (@(posedge clk) disable iff (!rst_b)
        txn.valid && txn.secure && !grp_sec_c |=> seq_refused)
        else $error("Secure master reached a Non-secure group");
    AST_GROUP_BANK_MISMATCH: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && grp_sec_c != bank_sec_c |=> seq_refused)
        else $error("Group and bank security differ but permitted");
    AST_S_BANK_NESTED: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && bank_sec_c && stage_c == STAGE_NESTED |=> seq_refused)
        else $error("Nested translation in Secure bank permitted");
    AST_S_MASTER_STAGE: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && txn.secure && stage_c != STAGE_S1_S2_BYPASS |=> seq_refused)
        else $error("Secure master used a non stage-1 context");
    AST_IRQ_CROSS: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && state_reg.v1_mode && bank_sec_c != irq_sec_c |=> seq_refused)
        else $error("Cross-state context interrupt permitted");
    AST_WALK_ESCALATION: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && ((!txn.walk_secure[0] && txn.walk_secure[1]) || (!txn.walk_secure[1] && txn.walk_secure[2])
        || (!txn.walk_secure[2] && txn.target_secure) || (!bank_sec_c && txn.walk_secure[0])) |=> seq_refused)
        else $error("Walk escalated from Non-secure to Secure");
    AST_FAULT_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
        seq_refused |-> state_reg.last_fault == verdict.code && state_reg.fault_count ==
            ($past(state_reg.fault_count) == 8'hFF ? 8'hFF : $past(state_reg.fault_count) + 8'h01))
        else $error("Fault not counted");

    // Bus timing and register protection
    AST_APB_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
        apb_req.psel && apb_req.penable && !pready |=> pready ##1 !pready)
        else $error("Bus answer not after one wait cycle");
    AST_NS_WRITE_SCR: assert property (@(posedge clk) disable iff (!rst_b)
        seq_apb_access and (apb_req.pwrite && apb_req.pprot[1] && in_global && page_num == '0 && reg_off == OFF_SCR0)
        |=> $stable(state_reg.ns_groups) && $stable(state_reg.ns_banks))
        else $error("Non-secure access changed the partition");

    // Pairs, the fault route and verdict presence checked one by one so a failure names the rule it broke
    AST_S_GROUP_NS_BANK: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && grp_sec_c && !bank_sec_c
        |=> seq_refused)
        else $error("Secure group routed to a Non-secure bank");
    AST_S_BANK_NS_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && state_reg.v1_mode && bank_sec_c && !irq_sec_c
        |=> seq_refused)
        else $error("Secure bank used a Non-secure interrupt");
    AST_NS_BANK_S_WALK: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && !bank_sec_c && txn.walk_secure[0]
        |=> seq_refused)
        else $error("Non-secure bank started a Secure walk");
    AST_WALK_L3: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && !txn.walk_secure[1] && txn.walk_secure[2]
        |=> seq_refused)
        else $error("Walk entered Secure level 3");
    AST_WALK_TARGET: assert property (@(posedge clk) disable iff (!rst_b)
        in_ctx && !txn.walk_secure[2] && txn.target_secure
        |=> seq_refused)
        else $error("Non-secure walk reached Secure memory");
    AST_ROUTE_FAULT: assert property (@(posedge clk) disable iff (!rst_b)
        txn.valid && txn.route == ROUTE_FAULT
        |=> seq_refused && verdict.code == FLT_RANGE)
        else $error("Fault route not refused");
    AST_VERDICT_EVERY_TXN: assert property (@(posedge clk) disable iff (!rst_b)
        txn.valid
        |=> verdict.valid)
        else $error("Request without a verdict");
    AST_VERDICT_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
        !txn.valid
        |=> !verdict.valid && !verdict.permit)
        else $error("Verdict without a request");

    // The request still stands at the edge where pready is high
    AST_NS_SCR_ERROR: assert property (@(posedge clk) disable iff (!rst_b)
        pready && ns_acc_c && gp0_hit_c && (reg_off == OFF_SCR0 || reg_off == OFF_SCR1)
        |-> pslverr)
        else $error("Non-secure access to Secure control without error");
    AST_NS_IDR_VIEW: assert property (@(posedge clk) disable iff (!rst_b)
        pready && ns_acc_c && gp0_hit_c && reg_off == OFF_IDR1
        |-> prdata[IDR1_GROUPS_LSB +: IDX_W] == state_reg.ns_groups
            && prdata[IDR1_BANKS_LSB +: IDX_W] == state_reg.ns_banks)
        else $error("Non-secure view shows Secure resources");
    AST_PAGE_FIELDS: assert property (@(posedge clk) disable iff (!rst_b)
        pready && gp0_hit_c && reg_off == OFF_IDR1
        |-> prdata[IDR1_PCI_LSB +: 3] == PAGE_COUNT_INDEX && prdata[IDR1_PAGE64_BIT] == PAGE_64K)
        else $error("Page size fields wrong");
    AST_NS_BANK_HIDDEN: assert property (@(posedge clk) disable iff (!rst_b)
        pready && ns_acc_c && bank_hit && bank_sec_vec[bank_sel]
        |-> prdata == '0)
        else $error("Secure bank word shown to Non-secure access");
    AST_NS_BANK_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        seq_apb_access and (apb_req.pwrite && ns_acc_c && bank_hit && bank_sec_vec[bank_sel])
        |=> $stable(state_reg.ctc))
        else $error("Non-secure access wrote a Secure bank");

endmodule

// >>> src/spc_pkg.sv
package spc_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 8;

    // Register offsets inside global page 0 and inside each context bank page
    localparam logic [11:0] OFF_SCR0 = 12'h000;
    localparam logic [11:0] OFF_SCR1 = 12'h004;
    localparam logic [11:0] OFF_IDR1 = 12'h008;
    localparam logic [11:0] OFF_STAT = 12'h00C;
    localparam logic [11:0] OFF_CTC  = 12'h030;

    // Field positions
    localparam int SCR0_GROUPS_LSB = 0;
    localparam int SCR0_BANKS_LSB  = 8;
    localparam int SCR1_IRQS_LSB   = 0;
    localparam int SCR1_V1_BIT     = 8;
    localparam int IDR1_GROUPS_LSB = 0;
    localparam int IDR1_BANKS_LSB  = 8;
    localparam int IDR1_PCI_LSB    = 28;
    localparam int IDR1_PAGE64_BIT = 31;
    localparam int STAT_COUNT_LSB  = 0;
    localparam int STAT_CODE_LSB   = 8;

    // Page sizes as byte shifts
    localparam int PAGE_SHIFT_4K  = 12;
    localparam int PAGE_SHIFT_64K = 16;

    // Values after reset
    localparam logic [IDX_W-1:0]  NS_COUNT_RST = 8'h00;
    localparam logic              V1_MODE_RST  = 1'b0;
    localparam logic [DATA_W-1:0] CTC_RST      = 32'h0000_0000;

    typedef enum logic [1:0] {
        STAGE_S1_S2_BYPASS,
        STAGE_S2_ONLY,
        STAGE_NESTED,
        STAGE_RESERVED
    } spc_stage_type;

    typedef enum logic [1:0] {
        ROUTE_CONTEXT,
        ROUTE_BYPASS,
        ROUTE_FAULT
    } spc_route_type;

    typedef enum logic [3:0] {
        FLT_NONE,
        FLT_NS_TO_S_GROUP,
        FLT_S_TO_NS_GROUP,
        FLT_S_NOT_S1,
        FLT_NSGRP_SBANK,
        FLT_SGRP_NSBANK,
        FLT_S_NESTED,
        FLT_NSBANK_SIRQ,
        FLT_SBANK_NSIRQ,
        FLT_NSBANK_SWALK,
        FLT_WALK_L2,
        FLT_WALK_L3,
        FLT_TARGET,
        FLT_RANGE
    } spc_fault_type;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [2:0]        pprot;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } spc_apb_req_type;

    typedef struct packed {
        logic             valid;
        logic             secure;
        logic [IDX_W-1:0] group;
        spc_route_type    route;
        logic [IDX_W-1:0] bank;
        logic [IDX_W-1:0] irq;
        logic [2:0]       walk_secure;
        logic             target_secure;
    } spc_txn_type;

    typedef struct packed {
        logic          valid;
        logic          permit;
        spc_fault_type code;
    } spc_verdict_type;

endpackage

// >>> dv/spc_master_model.sv
module spc_master_model (
    input  wire logic            clk,
    output spc_pkg::spc_txn_type txn
);
    timeunit 1ns;
    timeprecision 1ns;
    import spc_pkg::*;

    initial txn = '0;

    // One request per call; fields are scrambled once valid drops so stale values never pass
    task automatic send(input spc_txn_type t);
        spc_txn_type r;
        @(posedge clk);
        txn <= t;
        @(posedge clk);
        r = spc_txn_type'(~t);
        r.valid = 1'b0;
        txn <= r;
    endtask
endmodule

// >>> dv/security_partition_checker_test.sv
module security_partition_checker_test;
    timeunit 1ns;
    timeprecision 1ns;
    import spc_pkg::*;

    localparam logic [31:0] PG   = 32'h0000_1000;
    localparam logic [31:0] CB0  = 32'h0001_0030;
    localparam logic [31:0] SCR0 = 32'h0000_0000;
    localparam logic [31:0] SCR1 = 32'h0000_0004;
    localparam logic [31:0] IDR1 = 32'h0000_0008;
    localparam logic [31:0] STAT = 32'h0000_000C;

    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    spc_apb_req_type       req = '0;
    logic [DATA_W-1:0]     prdata;
    logic                  pready;
    logic                  pslverr;
    spc_txn_type           txn;
    spc_verdict_type       verdict;
    int                    err_count = 0;
    int                    n_tests = 0;
    int                    n_flt = 0;
    logic [3:0]            last_code = 4'h0;

    always #50 clk = ~clk;

    spc_checker i_dut (
        .clk     (clk),
        .rst_b   (rst_b),
        .apb_req (req),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .txn     (txn),
        .verdict (verdict)
    );

    spc_master_model i_master (
        .clk (clk),
        .txn (txn)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic ns, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.pprot <= {1'b0, ns, 1'b0};
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk("apb wait", 2, n);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic ns, input logic [31:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, ns, a, d, rd, e);
        chk("wr pslverr", {31'h0, xe}, {31'h0, e});
    endtask

    task automatic rdc(input logic ns, input logic [31:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, ns, a, 32'h0, rd, e);
        chk("rd data", x, rd & m);
        chk("rd pslverr", 0, {31'h0, e});
    endtask

    function automatic spc_txn_type mk(logic s, int g, spc_route_type r, int b, int q, logic [2:0] w,
                                       logic t);
        mk = '{1'b1, s, g[7:0], r, b[7:0], q[7:0], w, t};
    endfunction

    task automatic run(input spc_txn_type t, input spc_fault_type x);
        i_master.send(t);
        @(negedge clk);
        chk("verdict valid", 1, {31'h0, verdict.valid});
        chk("verdict permit", {31'h0, x == FLT_NONE}, {31'h0, verdict.permit});
        chk("verdict code", {28'h0, x}, {28'h0, verdict.code});
        if (x != FLT_NONE) begin
            n_flt++;
            last_code = x;
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        err_count++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk("reset verdict", 0, {31'h0, verdict.valid});
        rdc(0, SCR0, 32'hFFFF_FFFF, 32'h0);
        rdc(0, IDR1, 32'hF000_0000, 32'h3000_0000);
        wr(1, SCR0, 32'h0000_0204, 1);
        rdc(0, SCR0, 32'hFFFF_FFFF, 32'h0);
        wr(0, SCR0, 32'h0000_0204, 0);
        wr(0, SCR1, 32'h0000_0104, 0);
        rdc(1, IDR1, 32'hF000_FFFF, 32'h3000_0204);
        wr(0, CB0 + 2 * PG, 32'h2, 0);
        wr(0, CB0 + 4 * PG, 32'h1, 0);
        wr(0, CB0, 32'h1, 0);
        wr(1, CB0 + 2 * PG, 32'h0, 0);
        rdc(0, CB0 + 2 * PG, 32'h3, 32'h2);
        rdc(1, CB0 + 2 * PG, 32'hFFFF_FFFF, 32'h0);
        rdc(1, CB0, 32'h3, 32'h1);
        rdc(0, 32'h0000_0100, 32'hFFFF_FFFF, 32'h0);
        rdc(0, CB0 + 9 * PG, 32'hFFFF_FFFF, 32'h0);
        rdc(0, 32'h0002_0030, 32'hFFFF_FFFF, 32'h0);
        // Boundaries: NS groups 0..3, NS banks 0..1, NS irqs 0..3
        run(mk(0, 4, ROUTE_CONTEXT, 1, 1, 3'b000, 0), FLT_NS_TO_S_GROUP);
        run(mk(1, 3, ROUTE_CONTEXT, 3, 5, 3'b000, 0), FLT_S_TO_NS_GROUP);
        run(mk(0, 3, ROUTE_CONTEXT, 2, 1, 3'b000, 0), FLT_NSGRP_SBANK);
        run(mk(1, 4, ROUTE_CONTEXT, 1, 5, 3'b000, 0), FLT_SGRP_NSBANK);
        run(mk(1, 4, ROUTE_CONTEXT, 2, 5, 3'b000, 0), FLT_S_NESTED);
        run(mk(1, 4, ROUTE_CONTEXT, 4, 5, 3'b000, 0), FLT_S_NOT_S1);
        run(mk(1, 15, ROUTE_CONTEXT, 3, 4, 3'b000, 0), FLT_NONE);
        run(mk(0, 3, ROUTE_CONTEXT, 1, 4, 3'b000, 0), FLT_NSBANK_SIRQ);
        run(mk(1, 4, ROUTE_CONTEXT, 3, 3, 3'b000, 0), FLT_SBANK_NSIRQ);
        run(mk(0, 3, ROUTE_CONTEXT, 1, 3, 3'b001, 0), FLT_NSBANK_SWALK);
        run(mk(0, 3, ROUTE_CONTEXT, 1, 3, 3'b010, 0), FLT_WALK_L2);
        run(mk(0, 3, ROUTE_CONTEXT, 1, 3, 3'b100, 0), FLT_WALK_L3);
        run(mk(0, 3, ROUTE_CONTEXT, 1, 3, 3'b000, 1), FLT_TARGET);
        run(mk(0, 0, ROUTE_CONTEXT, 0, 0, 3'b000, 0), FLT_NONE);
        run(mk(0, 3, ROUTE_BYPASS, 7, 7, 3'b111, 1), FLT_NONE);
        run(mk(1, 4, ROUTE_FAULT, 3, 5, 3'b000, 0), FLT_RANGE);
        run(mk(0, 16, ROUTE_CONTEXT, 1, 1, 3'b000, 0), FLT_RANGE);
        rdc(0, STAT, 32'h0000_0FFF, {20'h0, last_code, n_flt[7:0]});
        wr(0, SCR1, 32'h0000_0004, 0);
        run(mk(1, 4, ROUTE_CONTEXT, 3, 3, 3'b000, 0), FLT_NONE);
        wr(0, SCR0, 32'h0000_0206, 0);
        run(mk(0, 5, ROUTE_CONTEXT, 1, 1, 3'b000, 0), FLT_NONE);
        run(mk(1, 5, ROUTE_CONTEXT, 3, 5, 3'b000, 0), FLT_S_TO_NS_GROUP);
        final_report();
    end
endmodule
